// *** verilog/program_sequencer.sv ***
// Program sequencer: phase generator, fetch/execute pipeline, counter, table reads.
// Assumes a synchronous program memory answering by phase T3, an outside
// decoder giving a command at T4, and interrupt sources holding requests.
// Contract
// - Four system clocks, four one-hot phases, make one instruction cycle.
// - Fetch in one cycle, execute in the next; one instruction per cycle.
// - Counter-changing instructions take two cycles; the prefetched word is dropped.
// - Counter is 12 bits, covering 4096 words, no banking.
// - Counter advances by one after each fetch.
// - Satisfied skip drops the fetched word, dummy cycle, continues at counter+2.
// - Reset clears the counter to 000H.
// - Enabled first external interrupt, stack not full, vectors to 004H.
// - Enabled second external interrupt, stack not full, vectors to 008H.
// - Enabled timer A overflow, stack not full, vectors to 00CH.
// - Enabled timer B overflow, stack not full, vectors to 010H.
// - Enabled serial byte completion, stack not full, vectors to 014H.
// - Enabled clock or remote-control events share vector 018H.
// - Low-byte write replaces bits 7..0, keeps 11..8: jump within page.
// - Jump and call load all 12 bits from target; return from stack top.
// - Program memory is 4096 words of 16 bits.
// - Current-page table address is counter bits 11..8 with pointer.
// - Last-page table address is all-ones page with pointer.
// - Table read gives low byte to data memory, upper byte to 08H.
// - Counter low byte reads and writes at data address 06H.
// - After power-up or wake, hold execution for 1024 clocks.
// - Eight-level stack; call or interrupt pushes, return pops.
// - With stack full, pending interrupts wait until a return.
`timescale 1ns/1ps
`default_nettype none
`include "seq_defs.svh"
module program_sequencer #(
  parameter int PC_W        = `PC_W,
  parameter int DEPTH       = `STACK_LEVELS,
  parameter int SST_CYCLES  = `SST_CYC
) (
  input  wire logic              core_clk,     // 25 MHz system clock
  input  wire logic              rst_n,        // Async reset, low
  input  wire logic              ce,           // Clock enable, freezes all
  output logic      [PC_W-1:0]   pmem_addr,    // Program memory address
  input  wire logic [15:0]       pmem_data,    // Program memory word
  output logic      [15:0]       instr,        // Word in execute stage
  output logic                   instr_valid,  // Execute word is real
  output seq_pkg::phase_t        phase,        // Current phase
  input  wire seq_pkg::seq_cmd_t cmd,          // Decoder command at T4
  input  wire seq_pkg::dm_req_t  dm_req,       // Data memory write at T4
  output logic      [7:0]        dm_rdata,     // Read data, 06H..08H
  output logic                   tab_low_wr,   // Table low byte strobe
  output logic      [7:0]        tab_low_data, // Table low byte
  input  wire logic [`IRQ_N-1:0] irq_pend,     // Latched interrupt requests
  input  wire logic [`IRQ_N-1:0] irq_en,       // Per-source enables
  output logic      [`IRQ_N-1:0] irq_ack,      // One-hot acknowledge pulse
  input  wire logic              wake,         // Wake from halt
  output logic                   running       // Executing, not start-up
);
  import seq_pkg::*;

  phase_t             ph_ff;
  run_t               rs_ff;
  logic [PC_W-1:0]    pc_ff, fetch_addr_ff, pmem_addr_ff, nxt_pc;
  logic [15:0]        fetch_word_ff, instr_ff;
  logic               instr_valid_ff, cyc_tab_ff, tab_last_ff, tab_low_wr_ff;
  logic [7:0]         table_read_pointer_ff, table_read_high_byte_ff, dm_rdata_ff, tab_low_data_ff;
  logic [`IRQ_N-1:0]  irq_ack_ff, irq_go;
  logic [`SST_CNT_W-1:0] sst_cnt_ff;
  logic [PC_W-1:0]    stk_top;
  logic               stk_full, do_push, do_pop, flush, start_tab, go_halt;
  logic               exec, pcl_wr, table_read_pointer_wr, t4, irq_take, running_ff;
  cmd_kind_t          kind;

  // Lowest-index request wins
  function automatic logic [`IRQ_N-1:0] irq_pick(input logic [`IRQ_N-1:0] req);
    logic [`IRQ_N-1:0] pick;
    pick = '0;
    for (int i = `IRQ_N - 1; i >= 0; i--) begin
      if (req[i]) pick = '0;
      if (req[i]) pick[i] = 1'b1;
    end
    return pick;
  endfunction : irq_pick

  // Vector for a one-hot request
  function automatic logic [PC_W-1:0] irq_vec(input logic [`IRQ_N-1:0] sel);
    logic [PC_W-1:0] v;
    v = `VEC_RESET;
    if (sel[0]) v = `VEC_INT_A;
    else if (sel[1]) v = `VEC_INT_B;
    else if (sel[2]) v = `VEC_TMR_A;
    else if (sel[3]) v = `VEC_TMR_B;
    else if (sel[4]) v = `VEC_SERIAL;
    else if (sel[5]) v = `VEC_MULTI;
    return v;
  endfunction : irq_vec

  // Table address: current page or forced last page
  function automatic logic [PC_W-1:0] tab_addr(input logic last, input logic [PC_W-1:0] pc,
                                               input logic [7:0] ptr);
    return last ? {`LAST_PAGE, ptr} : {pc[PC_W-1:8], ptr};
  endfunction : tab_addr

  assign t4      = (rs_ff == RS_RUN) && (ph_ff == PH_T4);
  assign exec    = instr_valid_ff;
  assign kind    = exec ? cmd.kind : CK_NONE;
  assign pcl_wr  = t4 && exec && dm_req.wr && (dm_req.addr == `PCL_ADDR);
  assign table_read_pointer_wr = t4 && exec && dm_req.wr && (dm_req.addr == `TABLE_READ_POINTER_ADDR);
  // Stack full holds every request off; sources keep them latched
  assign irq_go  = stk_full ? '0 : irq_pick(irq_pend & irq_en);

  // Boundary decision; a low-byte write outranks the decoder command
  always_comb begin
    nxt_pc    = pc_ff;
    do_push   = 1'b0;
    do_pop    = 1'b0;
    flush     = 1'b0;
    start_tab = 1'b0;
    go_halt   = 1'b0;
    irq_take  = 1'b0;
    if (pcl_wr) begin
      nxt_pc = {pc_ff[PC_W-1:8], dm_req.wdata};
      flush  = 1'b1;
    end else begin
      case (kind)
        CK_SKIP: begin
          // Counter already passed the discarded word, so it stands at +2
          nxt_pc = pc_ff;
          flush  = 1'b1;
        end
        CK_JUMP: begin
          nxt_pc = cmd.target;
          flush  = 1'b1;
        end
        CK_CALL: begin
          nxt_pc  = cmd.target;
          do_push = 1'b1;
          flush   = 1'b1;
        end
        CK_RET: begin
          nxt_pc = stk_top;
          do_pop = 1'b1;
          flush  = 1'b1;
        end
        CK_TABC, CK_TABL: begin
          start_tab = 1'b1;
        end
        CK_HALT: begin
          nxt_pc  = fetch_addr_ff;
          go_halt = 1'b1;
          flush   = 1'b1;
        end
        default: begin
          // Only a non-branching boundary takes an interrupt
          if (irq_go != '0) begin
            nxt_pc   = irq_vec(irq_go);
            do_push  = 1'b1;
            irq_take = 1'b1;
            flush    = 1'b1;
          end
        end
      endcase
    end
  end

  // Start-up timer and run state; wake re-enters the start-up wait
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs_ff      <= RS_START;
      sst_cnt_ff <= '0;
      running_ff <= 1'b0;
    end else if (ce) begin
      case (rs_ff)
        RS_START: begin
          sst_cnt_ff <= sst_cnt_ff + 1'b1;
          if (sst_cnt_ff == `SST_CNT_W'(SST_CYCLES - 1)) begin
            rs_ff      <= RS_RUN;
            running_ff <= 1'b1;
          end
        end
        RS_RUN: begin
          sst_cnt_ff <= '0;
          if (t4 && go_halt) begin
            rs_ff      <= RS_HALT;
            running_ff <= 1'b0;
          end
        end
        RS_HALT: begin
          if (wake) rs_ff <= RS_START;
        end
        default: begin
          rs_ff      <= RS_START;
          running_ff <= 1'b0;
        end
      endcase
    end
  end

  // Phase ring, only while running
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_ff <= PH_T1;
    end else if (ce) begin
      if (rs_ff != RS_RUN) ph_ff <= PH_T1;
      else begin
        case (ph_ff)
          PH_T1:   ph_ff <= PH_T2;
          PH_T2:   ph_ff <= PH_T3;
          PH_T3:   ph_ff <= PH_T4;
          PH_T4:   ph_ff <= PH_T1;
          default: ph_ff <= PH_T1;
        endcase
      end
    end
  end

  // Counter and fetch address; a table cycle borrows the memory port
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_ff         <= `VEC_RESET;
      pmem_addr_ff  <= `VEC_RESET;
      fetch_addr_ff <= `VEC_RESET;
    end else if (ce && rs_ff == RS_RUN) begin
      if (ph_ff == PH_T1) begin
        pmem_addr_ff <= cyc_tab_ff ? tab_addr(tab_last_ff, pc_ff, table_read_pointer_ff) : pc_ff;
        if (!cyc_tab_ff) fetch_addr_ff <= pc_ff;
      end
      if (ph_ff == PH_T2 && !cyc_tab_ff) pc_ff <= pc_ff + `PC_STEP;
      if (t4) pc_ff <= nxt_pc;
    end
  end

  // Pipeline: T3 captures the fetch, T4 hands it to execute
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_word_ff  <= 16'h0000;
      instr_ff       <= 16'h0000;
      instr_valid_ff <= 1'b0;
      cyc_tab_ff     <= 1'b0;
      tab_last_ff    <= 1'b0;
    end else if (ce) begin
      if (rs_ff != RS_RUN) instr_valid_ff <= 1'b0;
      else if (ph_ff == PH_T3 && !cyc_tab_ff) fetch_word_ff <= pmem_data;
      else if (t4) begin
        cyc_tab_ff  <= start_tab;
        tab_last_ff <= (kind == CK_TABL);
        // Issuing a table read holds the prefetched word one more cycle
        if (!start_tab) instr_ff <= fetch_word_ff;
        instr_valid_ff <= !flush && !start_tab;
      end
    end
  end

  // Table data capture and the low-byte strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      table_read_high_byte_ff         <= 8'h00;
      tab_low_wr_ff   <= 1'b0;
      tab_low_data_ff <= 8'h00;
    end else if (ce) begin
      tab_low_wr_ff <= 1'b0;
      if (rs_ff == RS_RUN && ph_ff == PH_T3 && cyc_tab_ff) begin
        table_read_high_byte_ff         <= pmem_data[15:8];
        tab_low_data_ff <= pmem_data[7:0];
        tab_low_wr_ff   <= 1'b1;
      end
    end
  end

  // Pointer register and read-back; unmapped addresses read zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      table_read_pointer_ff     <= 8'h00;
      dm_rdata_ff <= 8'h00;
    end else if (ce) begin
      if (table_read_pointer_wr) table_read_pointer_ff <= dm_req.wdata;
      if (dm_req.addr == `PCL_ADDR) dm_rdata_ff <= pc_ff[7:0];
      else if (dm_req.addr == `TABLE_READ_POINTER_ADDR) dm_rdata_ff <= table_read_pointer_ff;
      else if (dm_req.addr == `TABLE_READ_HIGH_BYTE_ADDR) dm_rdata_ff <= table_read_high_byte_ff;
      else dm_rdata_ff <= 8'h00;
    end
  end

  // Acknowledge pulse lets the source clear its request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) irq_ack_ff <= '0;
    else if (ce) irq_ack_ff <= (t4 && irq_take) ? irq_go : '0;
  end

  // Pushed return is the next unexecuted word, as the fetched one
  ret_stack #(.DEPTH(DEPTH), .AW(PC_W)) u_stack (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .ce        (ce && t4),
    .push      (do_push),
    .pop       (do_pop),
    .push_addr (fetch_addr_ff),
    .top_addr  (stk_top),
    .full      (stk_full)
  );

  assign pmem_addr    = pmem_addr_ff;
  assign instr        = instr_ff;
  assign instr_valid  = instr_valid_ff;
  assign phase        = ph_ff;
  assign dm_rdata     = dm_rdata_ff;
  assign tab_low_wr   = tab_low_wr_ff;
  assign tab_low_data = tab_low_data_ff;
  assign irq_ack      = irq_ack_ff;
  assign running      = running_ff;

  // Checks on the sequencing
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_phase;
    (ce && running && ph_ff == PH_T1) ##1 ce[*3] |-> ph_ff == PH_T4;
  endproperty
  a_phase: assert property (p_phase) else $error("phase ring broken");
  property p_incr;
    (ce && running && ph_ff == PH_T2 && !cyc_tab_ff) |=> pc_ff == $past(pc_ff) + `PC_STEP;
  endproperty
  a_incr: assert property (p_incr) else $error("counter not advanced");
  property p_skip;
    (ce && t4 && kind == CK_SKIP && !pcl_wr)
      |=> (pc_ff == $past(pc_ff)) && !instr_valid_ff;
  endproperty
  a_skip: assert property (p_skip) else $error("skip misdirected");
  property p_jump;
    (ce && t4 && kind == CK_JUMP && !pcl_wr) |=> pc_ff == $past(cmd.target) && !instr_valid_ff;
  endproperty
  a_jump: assert property (p_jump) else $error("jump not two cycles");
  property p_reset;
    $rose(rst_n) |-> pc_ff == `VEC_RESET && !instr_valid_ff;
  endproperty
  a_reset: assert property (p_reset) else $error("reset address wrong");
  property p_pcl;
    pcl_wr && ce |=> pc_ff == {$past(pc_ff[PC_W-1:8]), $past(dm_req.wdata)};
  endproperty
  a_pcl: assert property (p_pcl) else $error("low byte jump wrong");
  property p_last_page;
    (ce && running && ph_ff == PH_T1 && cyc_tab_ff && tab_last_ff)
      |=> pmem_addr_ff == {`LAST_PAGE, $past(table_read_pointer_ff)};
  endproperty
  a_last_page: assert property (p_last_page) else $error("last page address wrong");
  property p_full_hold;
    (ce && t4 && stk_full) |=> irq_ack_ff == '0;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("ack while stack full");
  property p_vec_a;
    (ce && irq_ack_ff[0]) |-> pc_ff == `VEC_INT_A && !instr_valid_ff;
  endproperty
  a_vec_a: assert property (p_vec_a) else $error("vector A wrong");
  property p_startup;
    rs_ff == RS_START |-> !instr_valid_ff && ph_ff == PH_T1;
  endproperty
  a_startup: assert property (p_startup) else $error("execution during start-up");

  c_skip: cover property (ce && t4 && kind == CK_SKIP);
  c_irq: cover property (ce && irq_ack_ff != '0);
  c_table: cover property (ce && tab_low_wr_ff);
  c_ret: cover property (ce && t4 && kind == CK_RET);
endmodule : program_sequencer
`default_nettype wire

// *** verilog/seq_defs.svh ***
// Constants of the program sequencer: addresses, vectors, timing.
// Assumes inclusion by bare name from the sequencer package and modules.
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH
`define PC_W          12
`define PAGE_W        4
`define STACK_LEVELS  8
`define PCL_ADDR      8'h06
`define TABLE_READ_POINTER_ADDR     8'h07
`define TABLE_READ_HIGH_BYTE_ADDR     8'h08
`define VEC_RESET     12'h000
`define VEC_INT_A     12'h004
`define VEC_INT_B     12'h008
`define VEC_TMR_A     12'h00C
`define VEC_TMR_B     12'h010
`define VEC_SERIAL    12'h014
`define VEC_MULTI     12'h018
`define LAST_PAGE     4'hF
`define PC_STEP       12'h001
`define SST_TSYS      1024
`define SST_CYC       (`SST_TSYS * 1)
`define SST_CNT_W     11
`define IRQ_N         6
`endif

// *** verilog/seq_pkg.sv ***
// Types shared by the program sequencer and its return stack.
// Assumes seq_defs.svh is on the include path.
`include "seq_defs.svh"
package seq_pkg;
  typedef enum logic [3:0] {
    PH_T1 = 4'b0001,
    PH_T2 = 4'b0010,
    PH_T3 = 4'b0100,
    PH_T4 = 4'b1000
  } phase_t;
  typedef enum logic [2:0] {
    RS_START = 3'b001,
    RS_RUN   = 3'b010,
    RS_HALT  = 3'b100
  } run_t;
  typedef enum logic [2:0] {
    CK_NONE = 3'h0,
    CK_SKIP = 3'h1,
    CK_JUMP = 3'h2,
    CK_CALL = 3'h3,
    CK_RET  = 3'h4,
    CK_TABC = 3'h5,
    CK_TABL = 3'h6,
    CK_HALT = 3'h7
  } cmd_kind_t;
  typedef struct packed {
    cmd_kind_t         kind;
    logic [`PC_W-1:0]  target;
  } seq_cmd_t;
  typedef struct packed {
    logic              wr;
    logic [7:0]        addr;
    logic [7:0]        wdata;
  } dm_req_t;
endpackage : seq_pkg

// *** verilog/ret_stack.sv ***
// Return-address stack, circular, eight levels by default.
// Assumes push and pop never arrive together; a push when full drops the oldest.
`timescale 1ns/1ps
`default_nettype none
`include "seq_defs.svh"
module ret_stack #(
  parameter int DEPTH = `STACK_LEVELS,
  parameter int AW    = `PC_W
) (
  input  wire logic          core_clk,   // System clock
  input  wire logic          rst_n,      // Async reset, low
  input  wire logic          ce,         // Clock enable
  input  wire logic          push,       // Store push_addr
  input  wire logic          pop,        // Drop top entry
  input  wire logic [AW-1:0] push_addr,  // Address pushed
  output logic      [AW-1:0] top_addr,   // Most recent entry
  output logic               full        // All levels used
);
  import seq_pkg::*;
  localparam int PW = $clog2(DEPTH);
  logic [AW-1:0] mem [DEPTH];
  logic [PW-1:0] ptr_ff;
  logic [PW:0]   cnt_ff;

  // Storage has no reset; only the pointer and count are control state
  always_ff @(posedge core_clk) begin
    if (ce && push) begin
      mem[ptr_ff] <= push_addr;
    end
  end

  // Pointer wraps, so overflow silently loses the oldest entry
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_ff <= '0;
      cnt_ff <= '0;
    end else if (ce && push) begin
      ptr_ff <= ptr_ff + 1'b1;
      if (cnt_ff != (PW+1)'(DEPTH)) cnt_ff <= cnt_ff + 1'b1;
    end else if (ce && pop) begin
      ptr_ff <= ptr_ff - 1'b1;
      if (cnt_ff != '0) cnt_ff <= cnt_ff - 1'b1;
    end
  end

  assign top_addr = mem[ptr_ff - 1'b1];
  assign full     = (cnt_ff == (PW+1)'(DEPTH));
endmodule : ret_stack
`default_nettype wire

// *** testbench/prog_mem_model.sv ***
// Program memory and interrupt request sources facing the sequencer.
// Assumes the sequencer samples the word at phase T3 and acks one-hot.
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
  input  wire logic        core_clk,  // System clock
  input  wire logic        rst_n,     // Async reset, low
  input  wire logic [11:0] pmem_addr, // Fetch address
  output logic      [15:0] pmem_data, // Word, one clock later
  input  wire logic [5:0]  raise,     // Bench request strobes
  input  wire logic [5:0]  irq_ack,   // Acknowledge from sequencer
  output logic      [5:0]  irq_pend   // Latched requests
);
  logic [15:0] mem [4096];

  // Word unique per address, so a wrong fetch always shows
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = {i[3:0], i[11:0]} ^ 16'h5AC3;
    end
  end

  // Synchronous read; the address stands all cycle, so T3 sees it settled
  always_ff @(posedge core_clk) begin
    pmem_data <= mem[pmem_addr];
  end

  // Request held until acknowledged, also while the stack is full
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pend <= 6'h00;
    end else begin
      irq_pend <= (irq_pend & ~irq_ack) | raise;
    end
  end
endmodule : prog_mem_model
`default_nettype wire

// *** testbench/program_sequencer_test.sv ***
// Self-checking bench for the program sequencer with memory model.
// Assumes start-up wait shortened to 8 clocks and one command per cycle.
`timescale 1ns/1ps
`default_nettype none
module program_sequencer_test;
  import seq_pkg::*;
  localparam dm_req_t idle_req = '{1'b0, 8'h30, 8'h00};
  logic        core_clk, rst_n, ce, wake, running, instr_valid, tab_low_wr, prev_run;
  logic [11:0] pmem_addr, cur;
  logic [15:0] pmem_data, instr;
  logic [7:0]  dm_rdata, tab_low_data, hi_m;
  logic [5:0]  irq_pend, irq_en, irq_ack, raise, raise_nxt, en_m, pend_m;
  phase_t      phase, prev_ph;
  seq_cmd_t    cmd;
  dm_req_t     dm_req;
  logic [11:0] stk[$];
  logic [15:0] exp_q[$];
  int          error_cnt, tests_run;

  program_sequencer #(.SST_CYCLES(8)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .pmem_addr(pmem_addr),
    .pmem_data(pmem_data), .instr(instr), .instr_valid(instr_valid), .phase(phase),
    .cmd(cmd), .dm_req(dm_req), .dm_rdata(dm_rdata), .tab_low_wr(tab_low_wr),
    .tab_low_data(tab_low_data), .irq_pend(irq_pend), .irq_en(irq_en),
    .irq_ack(irq_ack), .wake(wake), .running(running));
  prog_mem_model i_mem (
    .core_clk(core_clk), .rst_n(rst_n), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
    .raise(raise), .irq_ack(irq_ack), .irq_pend(irq_pend));

  // 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  function automatic logic [15:0] wd(input logic [11:0] a);
    return {a[3:0], a} ^ 16'h5AC3;
  endfunction : wd

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic done(input string s);
    $display("test %s finished, mismatches so far %0d", s, error_cnt);
  endtask : done

  // One instruction: command at T4, note the next executed word
  task automatic step(input cmd_kind_t k, input logic [11:0] t, input dm_req_t d,
                      input logic [8:0] rx);
    int          n;
    logic [5:0]  hit, ack_e, ack_d;
    logic [11:0] nxt;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (!(phase === PH_T2 && instr_valid === 1'b1) && n < 400);
    if (n >= 400) chk("instr_valid", 16'h0001, 16'(instr_valid));
    @(posedge core_clk);
    raise <= raise_nxt;
    irq_en <= en_m;
    pend_m |= raise_nxt;
    raise_nxt = 6'h00;
    @(posedge core_clk);
    raise <= 6'h00;
    cmd <= '{k, t};
    dm_req <= d;
    @(posedge core_clk);
    cmd <= '{CK_NONE, 12'($urandom)};
    dm_req <= '{1'b0, d.addr, 8'($urandom)};
    hit = pend_m & en_m;
    nxt = cur + 12'h001;
    ack_e = 6'h00;
    ack_d = 6'h00;
    if (d.wr && d.addr == 8'h06) nxt = {nxt[11:8], d.wdata};
    else if (k == CK_NONE && hit != 6'h00 && stk.size() < 8) begin
      n = 0;
      while (!hit[n]) n++;
      ack_e = 6'(1 << n);
      pend_m[n] = 1'b0;
      stk.push_back(nxt);
      nxt = 12'(4 * (n + 1));
    end else begin
      case (k)
        CK_SKIP: nxt = cur + 12'h002;
        CK_JUMP: nxt = t;
        CK_CALL: begin
          stk.push_back(nxt);
          nxt = t;
        end
        CK_RET:  nxt = stk.pop_back();
        default: ;
      endcase
    end
    // A branch ends in a dummy cycle whose boundary may take a request
    if ((k == CK_SKIP || k == CK_JUMP || k == CK_CALL || k == CK_RET)
        && !(d.wr && d.addr == 8'h06) && hit != 6'h00 && stk.size() < 8) begin
      n = 0;
      while (!hit[n]) n++;
      ack_d = 6'(1 << n);
      pend_m[n] = 1'b0;
      stk.push_back(nxt);
      nxt = 12'(4 * (n + 1));
    end
    cur = nxt;
    exp_q.push_back(wd(nxt));
    @(negedge core_clk);
    chk("irq_ack", 16'(ack_e), 16'(irq_ack));
    if (rx[8]) chk("dm_rdata", 16'(rx[7:0]), 16'(dm_rdata));
    if (ack_d != 6'h00) begin
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      chk("irq_ack", 16'(ack_d), 16'(irq_ack));
    end
  endtask : step

  // Pointer load, table read, then high byte read-back
  task automatic tab(input cmd_kind_t k);
    logic [7:0]  p;
    logic [11:0] ta;
    logic [15:0] w;
    int          n;
    p = 8'($urandom);
    step(CK_NONE, 12'h000, '{1'b1, 8'h07, p}, 9'h000);
    ta = {(k == CK_TABL) ? 4'hF : cur[11:8], p};
    w = wd(ta);
    step(k, 12'h000, '{1'b0, 8'h07, 8'h00}, {1'b1, p});
    n = 0;
    while (tab_low_wr !== 1'b1 && n < 12) begin
      @(negedge core_clk);
      n++;
    end
    chk("tab_low_data", {8'h00, w[7:0]}, {8'h00, tab_low_data});
    hi_m = w[15:8];
    step(CK_NONE, 12'h000, '{1'b0, 8'h08, 8'h00}, {1'b1, hi_m});
  endtask : tab

  // Executed-word and phase watcher
  initial begin
    prev_run = 1'b0;
    forever begin
      @(negedge core_clk);
      if (running === 1'b1 && prev_run)
        chk("phase", 16'({prev_ph[2:0], prev_ph[3]}), 16'(phase));
      prev_run = (running === 1'b1);
      prev_ph = phase;
      if (phase === PH_T1 && instr_valid === 1'b1 && exp_q.size() > 0)
        chk("instr", exp_q.pop_front(), instr);
    end
  end

  // Hang guard, well past the expected few hundred clocks
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0; ce = 1'b1; wake = 1'b0; cmd = '{CK_NONE, 12'h000}; dm_req = idle_req;
    irq_en = 6'h00; raise = 6'h00; raise_nxt = 6'h00; en_m = 6'h00; pend_m = 6'h00;
    error_cnt = 0; tests_run = 0; cur = 12'h000; hi_m = 8'h00;
    void'($urandom(32'hBA1A));
    exp_q.push_back(wd(12'h000));
    repeat (5) @(posedge core_clk);
    chk("pmem_addr", 16'h0000, 16'(pmem_addr));
    rst_n <= 1'b1;
    repeat (7) @(posedge core_clk);
    @(negedge core_clk);
    chk("running", 16'h0000, 16'(running));
    @(negedge core_clk);
    chk("running", 16'h0001, 16'(running));
    done("startup");
    for (int i = 0; i < 3; i++) step(CK_NONE, 12'h000, idle_req, 9'h100);
    step(CK_JUMP, 12'hFFE, idle_req, 9'h000);
    step(CK_SKIP, 12'h000, idle_req, 9'h000);
    step(CK_SKIP, 12'h000, idle_req, 9'h000);
    step(CK_JUMP, 12'h1FF, idle_req, 9'h000);
    step(CK_NONE, 12'h000, '{1'b1, 8'h06, 8'($urandom)}, 9'h000);
    done("sequence");
    for (int i = 0; i < 8; i++) step(CK_CALL, 12'($urandom), idle_req, 9'h000);
    en_m = 6'h3F;
    raise_nxt = 6'h01;
    step(CK_NONE, 12'h000, idle_req, 9'h000);
    step(CK_RET, 12'h000, idle_req, 9'h000);
    step(CK_NONE, 12'h000, idle_req, 9'h000);
    for (int i = 0; i < 8; i++) step(CK_RET, 12'h000, idle_req, 9'h000);
    done("stack");
    en_m = 6'h00;
    raise_nxt = 6'h3F;
    step(CK_NONE, 12'h000, idle_req, 9'h000);
    for (int i = 5; i >= 0; i--) begin
      en_m = 6'(1 << i);
      step(CK_NONE, 12'h000, idle_req, 9'h000);
      step(CK_RET, 12'h000, idle_req, 9'h000);
    end
    en_m = 6'h00;
    done("vectors");
    step(CK_JUMP, {4'($urandom), 8'h40}, idle_req, 9'h000);
    tab(CK_TABC);
    tab(CK_TABL);
    step(CK_NONE, 12'h000, '{1'b1, 8'h08, ~hi_m}, 9'h000);
    step(CK_NONE, 12'h000, '{1'b0, 8'h08, 8'h00}, {1'b1, hi_m});
    done("tables");
    step(CK_HALT, 12'h000, idle_req, 9'h000);
    repeat (2) @(posedge core_clk);
    wake <= 1'b1;
    @(negedge core_clk);
    chk("running", 16'h0000, 16'(running));
    @(posedge core_clk);
    wake <= 1'b0;
    step(CK_NONE, 12'h000, idle_req, 9'h000);
    step(CK_NONE, 12'h000, idle_req, 9'h000);
    done("halt");
    @(posedge core_clk);
    rst_n <= 1'b0;
    exp_q.delete();
    stk.delete();
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk("pmem_addr", 16'h0000, 16'(pmem_addr));
    cur = 12'h000;
    exp_q.push_back(wd(12'h000));
    @(posedge core_clk);
    rst_n <= 1'b1;
    step(CK_NONE, 12'h000, idle_req, 9'h000);
    step(CK_NONE, 12'h000, idle_req, 9'h000);
    done("rereset");
    tally_and_finish();
  end
endmodule : program_sequencer_test
`default_nettype wire
